// file: logic/pwm_gen_defs.svh
/*
 * register offsets, field positions and reset values for the
 * pwm generator channel. assumes inclusion by bare name from logic/.
 */
`ifndef PWM_GEN_DEFS_SVH
`define PWM_GEN_DEFS_SVH

// ****************************************************************
// register word indices; the byte address is four times the index
// ****************************************************************
`define OFS_GLOBAL_TB_CTRL 4'h0
`define OFS_GEN_CONTROL    4'h1
`define OFS_GEN_DUTY       4'h2
`define OFS_MASTER_DUTY    4'h3
`define OFS_GEN_PHASE      4'h4
`define OFS_GEN_DEAD_TIME  4'h5
`define OFS_OUTPUT_CONTROL 4'h6
`define OFS_MASTER_PERIOD  4'h7
`define OFS_GEN_PERIOD     4'h8
`define OFS_STATUS         4'h9

// ****************************************************************
// field positions
// ****************************************************************
`define BIT_MODULE_EN      15
`define BIT_TB_SELECT      9
`define BIT_DUTY_SELECT    8
`define BIT_IMMEDIATE      0
`define FLD_OUT_MODE_HI    11
`define FLD_OUT_MODE_LO    10
`define BIT_OVR_EN_HIGH    9
`define BIT_OVR_EN_LOW     8
`define FLD_OVR_DATA_HI    3
`define FLD_OVR_DATA_LO    2
`define BIT_OVR_SYNC       0

// ****************************************************************
// reset values
// ****************************************************************
`define RST_GLOBAL_TB_CTRL 16'h0000
`define RST_GEN_CONTROL    16'h0000
`define RST_DUTY           16'h0000
`define RST_PHASE          16'h0000
`define RST_DEAD_TIME      16'h0000
`define RST_OUTPUT_CONTROL 16'h0000
`define RST_PERIOD         16'h00ff

`endif

// file: logic/pwm_gen_pkg.sv
/*
 * types shared by the pwm generator channel files.
 * assumes nothing of its surroundings.
 */
package pwm_gen_pkg;

  typedef enum logic [1:0] {
    MODE_COMPLEMENTARY,
    MODE_PUSH_PULL,
    MODE_REDUNDANT,
    MODE_INDEPENDENT
  } out_mode_e;

  typedef enum logic [1:0] {
    DT_IDLE,
    DT_WAIT_HIGH,
    DT_WAIT_LOW
  } dead_state_e;

  typedef logic [15:0] word_t;

endpackage : pwm_gen_pkg

// file: logic/pwm_timebase.sv
/*
 * one free-running period counter with a boundary pulse.
 * assumes a single clock domain; used twice (master and own time base).
 */
module pwm_timebase
  import pwm_gen_pkg::*;
(
  input  wire logic  core_clk, // clock
  input  wire logic  reset,    // sync reset, active high
  input  wire logic  clk_en,   // freezes state while low
  input  wire logic  run,      // counting allowed
  input  wire word_t period,   // last count of the period
  output word_t      count,    // present count
  output logic       boundary  // one-cycle pulse at rollover
);

  // the boundary marks the last count, so loads taken on it land on the
  // wrap edge and a new period never starts with a stale compare value
  assign boundary = run && (count >= period);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      count <= 16'h0000;
    end else if (clk_en) begin
      if (!run || count >= period) begin
        count <= 16'h0000;
      end else begin
        count <= count + 16'h0001;
      end
    end
  end

endmodule : pwm_timebase

// file: logic/pwm_generator_update_control.sv
/*
 * one pwm generator channel: time base choice, buffered or immediate
 * update, output modes, dead time and override, behind an axi4-lite slave.
 * assumes one clock; the gate drivers sit on high_side_out/low_side_out.
 */
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
// Contract
// [RQ1] gen_control bit 9 zero selects master time base, one selects own.
// [RQ2] gen_control bit 0 set applies duty at once, else at period boundary.
// [RQ3] pwm runs only while global_timebase_control bit 15 is set.
// [RQ4] output_control bits 11:10: 10 redundant, 01 push-pull.
// [RQ5] gen_control bit 8 picks own duty (0) or shared master duty (1).
// [RQ6] override sync bit 0 clear applies override changes on next clock.
// [RQ7] override forces outputs to override data; clearing resumes pwm.
// [RQ8] phase change on master base still gets dead time at boundary.
// [RQ9] nonzero to zero duty in redundant/push-pull yields no glitch pulse.
// [RQ10] software times immediate writes near period boundary.
// [RQ11] all control registers are written and read back over the bus.
module pwm_generator_update_control
  import pwm_gen_pkg::*;
(
  input  wire logic        core_clk,      // 25 mhz clock
  input  wire logic        reset,         // sync reset, active high
  input  wire logic        clk_en,        // freezes all state while low
  input  wire logic [31:0] s_axi_awaddr,  // write address
  input  wire logic        s_axi_awvalid, // write address valid
  output logic             s_axi_awready, // write address ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // byte enables
  input  wire logic        s_axi_wvalid,  // write data valid
  output logic             s_axi_wready,  // write data ready
  output logic [1:0]       s_axi_bresp,   // write response
  output logic             s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  input  wire logic [31:0] s_axi_araddr,  // read address
  input  wire logic        s_axi_arvalid, // read address valid
  output logic             s_axi_arready, // read address ready
  output logic [31:0]      s_axi_rdata,   // read data
  output logic [1:0]       s_axi_rresp,   // read response
  output logic             s_axi_rvalid,  // read data valid
  input  wire logic        s_axi_rready,  // read data ready
  output logic             high_side_out, // high gate drive
  output logic             low_side_out   // low gate drive
);
`include "pwm_gen_defs.svh"

  // ****************************************************************
  // register file
  // ****************************************************************
  word_t global_timebase_control_q;
  word_t gen_control_q;
  word_t gen_duty_q;
  word_t master_duty_q;
  word_t gen_phase_q;
  word_t gen_dead_time_q;
  word_t output_control_q;
  word_t master_period_q;
  word_t gen_period_q;

  logic        aw_held_q;
  logic        w_held_q;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_fire;
  logic [3:0]  wr_idx;
  logic        wr_ok;

  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_idx  = awaddr_q[5:2];
  assign wr_ok   = (awaddr_q[31:6] == 26'h0) && (wr_idx <= `OFS_GEN_PERIOD);

  function automatic word_t merge(input word_t old, input logic [31:0] d, input logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge

  // address and data are taken in either order, one write at a time
  always_ff @(posedge core_clk) begin
    if (reset) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      awaddr_q      <= 32'h0;
      wdata_q       <= 32'h0;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else if (clk_en) begin
      s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      global_timebase_control_q <= `RST_GLOBAL_TB_CTRL;
      gen_control_q             <= `RST_GEN_CONTROL;
      gen_duty_q                <= `RST_DUTY;
      master_duty_q             <= `RST_DUTY;
      gen_phase_q               <= `RST_PHASE;
      gen_dead_time_q           <= `RST_DEAD_TIME;
      output_control_q          <= `RST_OUTPUT_CONTROL;
      master_period_q           <= `RST_PERIOD;
      gen_period_q              <= `RST_PERIOD;
    end else if (clk_en && wr_fire && wr_ok) begin
      case (wr_idx) // RQ11
        `OFS_GLOBAL_TB_CTRL: global_timebase_control_q <= merge(global_timebase_control_q, wdata_q, wstrb_q);
        `OFS_GEN_CONTROL:    gen_control_q    <= merge(gen_control_q, wdata_q, wstrb_q);
        `OFS_GEN_DUTY:       gen_duty_q       <= merge(gen_duty_q, wdata_q, wstrb_q);
        `OFS_MASTER_DUTY:    master_duty_q    <= merge(master_duty_q, wdata_q, wstrb_q);
        `OFS_GEN_PHASE:      gen_phase_q      <= merge(gen_phase_q, wdata_q, wstrb_q);
        `OFS_GEN_DEAD_TIME:  gen_dead_time_q  <= merge(gen_dead_time_q, wdata_q, wstrb_q);
        `OFS_OUTPUT_CONTROL: output_control_q <= merge(output_control_q, wdata_q, wstrb_q);
        `OFS_MASTER_PERIOD:  master_period_q  <= merge(master_period_q, wdata_q, wstrb_q);
        `OFS_GEN_PERIOD:     gen_period_q     <= merge(gen_period_q, wdata_q, wstrb_q);
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // time bases and active (shadow) values
  // ****************************************************************
  logic  pwm_run;
  word_t master_count;
  word_t own_count;
  logic  master_edge;
  logic  own_edge;
  logic  use_own_tb;
  word_t tb_count;
  logic  tb_edge;
  word_t duty_src;
  logic  immediate;
  word_t duty_q;
  word_t phase_q;
  logic  state_q;
  word_t status_word;

  assign pwm_run    = global_timebase_control_q[`BIT_MODULE_EN]; // RQ3
  assign use_own_tb = gen_control_q[`BIT_TB_SELECT];
  assign tb_count   = use_own_tb ? own_count : master_count; // RQ1
  assign tb_edge    = use_own_tb ? own_edge : master_edge; // RQ1
  assign duty_src   = gen_control_q[`BIT_DUTY_SELECT] ? master_duty_q : gen_duty_q; // RQ5
  assign immediate  = gen_control_q[`BIT_IMMEDIATE];

  pwm_timebase u_master_tb (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .run      (pwm_run),
    .period   (master_period_q),
    .count    (master_count),
    .boundary (master_edge)
  );

  pwm_timebase u_own_tb (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .run      (pwm_run),
    .period   (gen_period_q),
    .count    (own_count),
    .boundary (own_edge)
  );

  // with immediate clear, buffered values are loaded only at the boundary or while pwm is stopped, so a zero duty never
  // meets a stale compare mid-period; this is what kills the one-clock glitch
  always_ff @(posedge core_clk) begin
    if (reset) begin
      duty_q  <= `RST_DUTY;
      phase_q <= `RST_PHASE;
    end else if (clk_en) begin
      if (immediate || tb_edge || !pwm_run) begin // RQ2 RQ9
        duty_q  <= duty_src;
        phase_q <= gen_phase_q;
      end
    end
  end

  // raw pwm: high while count sits in [phase, phase+duty)
  logic  raw_on;
  word_t rel_count;
  assign rel_count = tb_count - phase_q;
  assign raw_on    = pwm_run && (duty_q != 16'h0000) && (tb_count >= phase_q) && (rel_count < duty_q); // RQ9

  // push-pull steering toggles each period
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= 1'b0;
    end else if (clk_en) begin
      if (!pwm_run) begin
        state_q <= 1'b0;
      end else if (tb_edge) begin
        state_q <= !state_q;
      end
    end
  end

  // ****************************************************************
  // dead time on complementary transitions
  // ****************************************************************
  // the dead counter is driven by the raw level alone, so any edge, phase
  // change at a boundary included, passes through the gap whenever dead time is nonzero
  dead_state_e dt_state_q;
  word_t       dt_cnt_q;
  logic        raw_prev_q;
  logic        comp_high;
  logic        comp_low;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      dt_state_q <= DT_IDLE;
      dt_cnt_q   <= 16'h0000;
      raw_prev_q <= 1'b0;
    end else if (clk_en) begin
      raw_prev_q <= raw_on;
      case (dt_state_q)
        // the edge cycle itself is the first cycle of the gap
        DT_IDLE: begin
          if (raw_on != raw_prev_q && gen_dead_time_q > 16'h0001) begin // RQ8
            dt_state_q <= raw_on ? DT_WAIT_HIGH : DT_WAIT_LOW;
            dt_cnt_q   <= gen_dead_time_q - 16'h0002;
          end
        end
        DT_WAIT_HIGH, DT_WAIT_LOW: begin
          if (raw_on != raw_prev_q && gen_dead_time_q > 16'h0001) begin
            dt_state_q <= raw_on ? DT_WAIT_HIGH : DT_WAIT_LOW;
            dt_cnt_q   <= gen_dead_time_q - 16'h0002;
          end else if (raw_on != raw_prev_q || dt_cnt_q == 16'h0000) begin
            dt_state_q <= DT_IDLE;
          end else begin
            dt_cnt_q <= dt_cnt_q - 16'h0001;
          end
        end
        default: dt_state_q <= DT_IDLE;
      endcase
    end
  end

  assign comp_high = raw_on && (dt_state_q == DT_IDLE) && (raw_on == raw_prev_q || gen_dead_time_q == 16'h0000);
  assign comp_low  = pwm_run && !raw_on && (dt_state_q == DT_IDLE)
                     && (raw_on == raw_prev_q || gen_dead_time_q == 16'h0000);

  // ****************************************************************
  // output mode, override and pins
  // ****************************************************************
  out_mode_e mode;
  logic      ovr_sync;
  logic [1:0] ovr_en_q;
  logic [1:0] ovr_dat_q;
  logic      pwm_high;
  logic      pwm_low;

  assign mode     = out_mode_e'(output_control_q[`FLD_OUT_MODE_HI:`FLD_OUT_MODE_LO]); // RQ4
  assign ovr_sync = output_control_q[`BIT_OVR_SYNC];

  always_comb begin
    case (mode) // RQ4
      MODE_REDUNDANT: begin
        pwm_high = raw_on;
        pwm_low  = raw_on;
      end
      MODE_PUSH_PULL: begin
        pwm_high = raw_on && !state_q;
        pwm_low  = raw_on && state_q;
      end
      MODE_COMPLEMENTARY: begin
        pwm_high = comp_high;
        pwm_low  = comp_low;
      end
      default: begin
        pwm_high = raw_on;
        pwm_low  = 1'b0;
      end
    endcase
  end

  // override takes effect at once unless sync asks for the period boundary
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ovr_en_q  <= 2'h0;
      ovr_dat_q <= 2'h0;
    end else if (clk_en) begin
      if (!ovr_sync || tb_edge || !pwm_run) begin // RQ6
        ovr_en_q  <= output_control_q[`BIT_OVR_EN_HIGH:`BIT_OVR_EN_LOW];
        ovr_dat_q <= output_control_q[`FLD_OVR_DATA_HI:`FLD_OVR_DATA_LO];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      high_side_out <= 1'b0;
      low_side_out  <= 1'b0;
    end else if (clk_en) begin
      high_side_out <= ovr_en_q[1] ? ovr_dat_q[1] : pwm_high; // RQ7
      low_side_out  <= ovr_en_q[0] ? ovr_dat_q[0] : pwm_low; // RQ7
    end
  end

  // ****************************************************************
  // read channel
  // ****************************************************************
  assign status_word = {tb_count[13:0], state_q, raw_on};

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'h0;
    end else if (clk_en) begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        s_axi_rdata  <= 32'h0;
        if (s_axi_araddr[31:6] != 26'h0) begin
          s_axi_rresp <= 2'h2;
        end else begin
          case (s_axi_araddr[5:2]) // RQ11
            `OFS_GLOBAL_TB_CTRL: s_axi_rdata <= {16'h0, global_timebase_control_q};
            `OFS_GEN_CONTROL:    s_axi_rdata <= {16'h0, gen_control_q};
            `OFS_GEN_DUTY:       s_axi_rdata <= {16'h0, gen_duty_q};
            `OFS_MASTER_DUTY:    s_axi_rdata <= {16'h0, master_duty_q};
            `OFS_GEN_PHASE:      s_axi_rdata <= {16'h0, gen_phase_q};
            `OFS_GEN_DEAD_TIME:  s_axi_rdata <= {16'h0, gen_dead_time_q};
            `OFS_OUTPUT_CONTROL: s_axi_rdata <= {16'h0, output_control_q};
            `OFS_MASTER_PERIOD:  s_axi_rdata <= {16'h0, master_period_q};
            `OFS_GEN_PERIOD:     s_axi_rdata <= {16'h0, gen_period_q};
            `OFS_STATUS:         s_axi_rdata <= {16'h0, status_word};
            default:             s_axi_rresp <= 2'h2;
          endcase
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_stopped_no_drive: assert property (!pwm_run && !(|ovr_en_q) && clk_en |=> !high_side_out && !low_side_out) // RQ3
    else $error("outputs active while module disabled");
  a_buffered_duty: assert property (clk_en && !immediate && !tb_edge && pwm_run |=> $stable(duty_q)) // RQ2
    else $error("buffered duty changed off boundary");
  a_immediate_duty: assert property (clk_en && immediate |=> duty_q == $past(duty_src)) // RQ2
    else $error("immediate duty not applied");
  a_duty_source: assert property (clk_en && immediate && gen_control_q[`BIT_DUTY_SELECT] |=> duty_q == $past(master_duty_q)) // RQ5
    else $error("master duty not selected");
  a_tb_select: assert property (!use_own_tb |-> tb_count == master_count) // RQ1
    else $error("wrong time base");
  a_redundant_same: assert property (clk_en && mode == MODE_REDUNDANT && !(|ovr_en_q) |=> high_side_out == low_side_out) // RQ4
    else $error("redundant outputs differ");
  a_zero_duty_quiet: assert property (duty_q == 16'h0000 |-> !raw_on) // RQ9
    else $error("pulse with zero duty");
  a_override_fast: assert property (clk_en && !ovr_sync |=> ovr_en_q == $past(output_control_q[9:8])) // RQ6
    else $error("override not applied on next clock");
  a_override_level: assert property (clk_en && ovr_en_q[1] |=> high_side_out == $past(ovr_dat_q[1])) // RQ7
    else $error("override level not driven");
  a_dead_gap: assert property (clk_en && mode == MODE_COMPLEMENTARY && gen_dead_time_q != 16'h0000 && raw_on != raw_prev_q
                               |-> !comp_high && !comp_low) // RQ8
    else $error("no dead time at transition");

  c_boundary_load: cover property (tb_edge && !immediate && duty_src != duty_q);
  c_dead_time: cover property (dt_state_q == DT_WAIT_HIGH);
  c_push_pull: cover property (mode == MODE_PUSH_PULL && low_side_out);
  c_override: cover property (ovr_en_q == 2'h3);

endmodule : pwm_generator_update_control

// file: testbench/gate_driver_model.sv
/*
 * behavioural gate driver pair on the two pwm outputs: counts cycles with
 * both gates on and keeps the shortest both-off gap before a turn-on.
 * assumes one clock and registered gate drives.
 */
module gate_driver_model (
  input  wire logic core_clk,      // clock
  input  wire logic clear,         // restarts the statistics
  input  wire logic high_side_out, // high gate drive
  input  wire logic low_side_out,  // low gate drive
  output int        overlap,       // cycles with both gates on
  output int        min_gap        // shortest off gap before a turn-on
);
  timeunit 1ns;
  timeprecision 1ns;
  int   gap;
  logic high_q;
  logic low_q;
  // ****************************************************************
  // a real bridge shorts the rail if both switches ever conduct
  // ****************************************************************
  always @(posedge core_clk) begin
    high_q <= high_side_out;
    low_q  <= low_side_out;
    if (clear) begin
      overlap <= 0;
      min_gap <= 99;
      gap     <= 99; // a gap cut short by the clear must not count
    end else begin
      if (high_side_out && low_side_out) overlap <= overlap + 1;
      gap <= (!high_side_out && !low_side_out) ? gap + 1 : 0;
      if (((high_side_out && !high_q) || (low_side_out && !low_q)) && gap < min_gap) min_gap <= gap;
    end
  end
endmodule : gate_driver_model

// file: testbench/tb_top.sv
/*
 * self-checking bench for the pwm generator channel: axi4-lite master tasks
 * and one task per scenario. assumes the gate driver model beside the dut.
 */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] GTB = 8'h00, CTL = 8'h04, DUTY = 8'h08, MDUTY = 8'h0c, PHASE = 8'h10;
  localparam logic [7:0] DT = 8'h14, OC = 8'h18, MPER = 8'h1c, GPER = 8'h20, STAT = 8'h24;
  logic        core_clk, reset, clk_en, clear, high_side_out, low_side_out;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, got;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  int          fails, checks_done, overlap, min_gap, nh, nl;
  logic [7:0]  ra [8] = '{CTL, DUTY, MDUTY, PHASE, DT, OC, MPER, GPER};
  logic [15:0] rv [8] = '{16'h0200, 16'h0004, 16'h0006, 16'h0000, 16'h0000, 16'h0000, 16'h0013, 16'h0009};

  pwm_generator_update_control u_dut (.core_clk, .reset, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .high_side_out, .low_side_out);
  gate_driver_model u_gates (.core_clk, .clear, .high_side_out, .low_side_out, .overlap, .min_gap);

  always #20 core_clk = ~core_clk;

  // ****************************************************************
  // reporting and bus tasks
  // ****************************************************************
  task chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task conclude();
    $display("mismatches %0d of %0d compares", fails, checks_done);
    if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task tmo();
    chk("handshake", 1, 0);
    conclude();
  endtask : tmo

  // channels are released one by one as each is taken
  task wr(input logic [7:0] a, input logic [15:0] d);
    int n;
    @(posedge core_clk);
    s_axi_awaddr  <= {24'h0, a};
    s_axi_wdata   <= {16'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
    if (n == 60) tmo();
  endtask : wr

  task rd(input logic [7:0] a);
    int n;
    @(posedge core_clk);
    s_axi_araddr  <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    got  = s_axi_rdata;
    resp = s_axi_rresp;
    if (n == 60) tmo();
  endtask : rd

  task meas(input int n);
    nh = 0;
    nl = 0;
    repeat (n) begin
      @(posedge core_clk);
      nh += int'(high_side_out);
      nl += int'(low_side_out);
    end
  endtask : meas

  // polls the period count in status; a window of five covers one poll step
  task sync(input int a, input int b);
    int n;
    for (n = 0; n < 100; n++) begin
      rd(STAT);
      if (got[15:2] >= a && got[15:2] <= b) break;
    end
    if (n == 100) tmo();
  endtask : sync

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_regs();
    rd(GPER);
    chk("gen_period reset", 32'h00ff, got);
    rd(8'h28);
    chk("unmapped rresp", 2'b10, resp);
    wr(8'h28, 16'h1234);
    chk("unmapped bresp", 2'b10, resp);
    foreach (ra[i]) wr(ra[i], rv[i]);
    foreach (ra[i]) begin
      rd(ra[i]);
      chk("readback", {16'h0, rv[i]}, got);
    end
  endtask : t_regs

  task t_bases();
    meas(40);
    chk("disabled high", 0, nh);
    chk("disabled low", 0, nl);
    wr(GTB, 16'h8000);
    repeat (25) @(posedge core_clk);
    meas(40);
    chk("own base high", 16, nh);
    chk("own base low", 24, nl);
    wr(CTL, 16'h0000);
    repeat (45) @(posedge core_clk);
    meas(40);
    chk("master base high", 8, nh);
    wr(CTL, 16'h0100);
    repeat (45) @(posedge core_clk);
    meas(40);
    chk("master duty high", 12, nh);
  endtask : t_bases

  task t_dead();
    wr(CTL, 16'h0000);
    wr(DUTY, 16'h0008);
    wr(DT, 16'h0002);
    repeat (45) @(posedge core_clk);
    meas(40);
    chk("dead high", 12, nh);
    chk("dead low", 20, nl);
    clear <= 1'b1;
    @(posedge core_clk);
    clear <= 1'b0;
    wr(PHASE, 16'h000f);
    repeat (60) @(posedge core_clk);
    chk("overlap", 0, overlap);
    chk("min gap", 2, min_gap);
  endtask : t_dead

  task t_imm();
    wr(DT, 16'h0000);
    wr(PHASE, 16'h0000);
    wr(DUTY, 16'h0000);
    wr(MPER, 16'h00c7);
    repeat (420) @(posedge core_clk);
    sync(10, 40);
    wr(DUTY, 16'h0096);
    meas(40);
    chk("buffered duty high", 0, nh);
    wr(CTL, 16'h0001);
    wr(DUTY, 16'h0000);
    sync(10, 40);
    wr(DUTY, 16'h0096);
    meas(40);
    chk("immediate duty high", 1, nh >= 35);
  endtask : t_imm

  task t_modes();
    wr(CTL, 16'h0000);
    wr(DUTY, 16'h0004);
    wr(MPER, 16'h0013);
    repeat (210) @(posedge core_clk);
    for (int m = 0; m < 3; m++) begin
      wr(OC, m == 0 ? 16'h0800 : m == 1 ? 16'h0400 : 16'h0c00);
      repeat (45) @(posedge core_clk);
      meas(40);
      chk("mode high", m == 1 ? 4 : 8, nh);
      chk("mode low", m == 0 ? 8 : m == 1 ? 4 : 0, nl);
      sync(6, 10);
      wr(DUTY, 16'h0000);
      meas(40);
      chk("zero duty pulses", 0, nh + nl);
      wr(DUTY, 16'h0004);
    end
  endtask : t_modes

  task t_ovr();
    wr(OC, 16'h0308);
    repeat (2) @(posedge core_clk);
    meas(20);
    chk("forced high", 20, nh);
    chk("forced low off", 0, nl);
    wr(OC, 16'h0304);
    repeat (2) @(posedge core_clk);
    meas(20);
    chk("forced high off", 0, nh);
    chk("forced low", 20, nl);
    sync(6, 10);
    wr(OC, 16'h0309);
    meas(2);
    chk("sync ovr held", 0, nh);
    repeat (10) @(posedge core_clk);
    meas(20);
    chk("sync ovr applied", 20, nh);
    wr(OC, 16'h0000);
    repeat (25) @(posedge core_clk);
    meas(40);
    chk("resumed high", 8, nh);
  endtask : t_ovr

  initial begin
    core_clk = 0;
    reset = 1;
    clk_en = 1;
    clear = 1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hf;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    clear <= 1'b0;
    t_regs();
    t_bases();
    t_dead();
    t_imm();
    t_modes();
    t_ovr();
    conclude();
  end
endmodule : tb_top
